// ==== rtl/pmb_bcast_port.sv ====
// file: per-port broadcast statistics and suppression
`timescale 1ns/10ps
module pmb_bcast_port
  import pmb_pkg::*;
#(
  parameter int unsigned CNT_W = 24,
  parameter int unsigned TOT_W = 32,
  parameter int unsigned TIM_W = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             tick_in,
  input  wire logic             frm_in,
  input  wire logic             lim_en_in,
  input  wire logic [CNT_W-1:0] thr_in,
  input  wire logic             peak_clr_in,
  output logic                  drop_out,
  output logic [TOT_W-1:0]      total_out,
  output logic [CNT_W-1:0]      peak_out,
  output logic [TIM_W-1:0]      since_out
);

  typedef struct packed {
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] peak;
    logic [TIM_W-1:0] since;
    logic [TOT_W-1:0] total;
    logic             drop;
  } pmb_port_t;

  pmb_port_t s_r;
  pmb_port_t s_nxt;
  logic [CNT_W-1:0] base_peak;
  logic [TIM_W-1:0] base_since;

  always_comb begin
    s_nxt = s_r;
    s_nxt.total = s_r.total + TOT_W'(frm_in);
    // a zero threshold means no limit, so an unprogrammed port never drops;
    // a frame in the boundary cycle opens the new window and is not judged by the old count
    s_nxt.drop = frm_in && lim_en_in && !tick_in && (thr_in != '0) && (s_r.win >= thr_in);
    base_peak  = peak_clr_in ? '0 : s_r.peak;
    base_since = peak_clr_in ? '0 : s_r.since;
    s_nxt.peak  = base_peak;
    s_nxt.since = base_since;
    if (tick_in) begin
      s_nxt.win = CNT_W'(frm_in);
      if (s_r.win > base_peak) begin
        s_nxt.peak  = s_r.win;
        s_nxt.since = '0;
      end else begin
        s_nxt.since = base_since + TIM_W'(1);
      end
    end else begin
      // window saturates rather than wrapping so a flood never looks small
      if (frm_in && (s_r.win != '1)) begin
        s_nxt.win = s_r.win + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign drop_out  = s_r.drop;
  assign total_out = s_r.total;
  assign peak_out  = s_r.peak;
  assign since_out = s_r.since;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence over_limit_s;
    frm_in && lim_en_in && !tick_in && (thr_in != '0) && (s_r.win >= thr_in);
  endsequence

  bcast_drop_a: assert property (over_limit_s |=> drop_out)
    else $error("broadcast over threshold not dropped");
  under_limit_a: assert property ((frm_in && (s_r.win < thr_in)) |=> !drop_out)
    else $error("broadcast under threshold dropped");
  win_clear_a: assert property (tick_in |=> (s_r.win == CNT_W'($past(frm_in))))
    else $error("window not restarted at second boundary");
  tick_nodrop_a: assert property (tick_in |=> !drop_out)
    else $error("broadcast judged against the previous second");
  peak_new_a: assert property ((tick_in && !peak_clr_in && (s_r.win > s_r.peak))
                               |=> (peak_out == $past(s_r.win)) && (since_out == '0))
    else $error("new peak not recorded");
  peak_clear_a: assert property ((peak_clr_in && !tick_in) |=> (peak_out == '0) && (since_out == '0))
    else $error("peak reset did not clear peak and time");
  total_cnt_a: assert property (frm_in |=> (total_out == $past(total_out) + TOT_W'(1)))
    else $error("total broadcast count not advanced");

endmodule : pmb_bcast_port

// ==== rtl/pmb_pkg.sv ====
// package: constants, register map and modes of the port mirror and broadcast limiter
package pmb_pkg;

  // one-second interval in clock cycles
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  // bus geometry
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;

  // register byte offsets
  localparam logic [AXI_AW-1:0] REG_CTRL     = 8'h00;
  localparam logic [AXI_AW-1:0] REG_MIR_CMD  = 8'h04;
  localparam logic [AXI_AW-1:0] REG_PORT_SEL = 8'h08;
  localparam logic [AXI_AW-1:0] REG_THRESH   = 8'h0C;
  localparam logic [AXI_AW-1:0] REG_TOTAL_RX = 8'h10;
  localparam logic [AXI_AW-1:0] REG_PEAK     = 8'h14;
  localparam logic [AXI_AW-1:0] REG_SINCE    = 8'h18;
  localparam logic [AXI_AW-1:0] REG_PEAK_RST = 8'h1C;
  localparam logic [AXI_AW-1:0] REG_SRC_LIST = 8'h20;
  localparam logic [AXI_AW-1:0] REG_DST_LIST = 8'h24;
  localparam logic [AXI_AW-1:0] REG_ERR_LIST = 8'h28;

  // field positions
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_COMMIT    = 2;
  localparam int unsigned MCMD_SRC_LSB   = 0;
  localparam int unsigned MCMD_DST_LSB   = 8;
  localparam int unsigned MCMD_FLD_W     = 8;
  localparam int unsigned MCMD_ADD       = 16;
  localparam int unsigned MCMD_ERR_ON    = 17;
  localparam int unsigned PEAK_RST_BIT   = 0;

  // responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // switching modes
  typedef enum logic [1:0] {
    PMB_MODE_BRIDGE         = 2'h0,
    PMB_MODE_TAGGED         = 2'h1,
    PMB_SECURE_VLAN_MODE    = 2'h2
  } pmb_mode_t;

  localparam logic [1:0] MODE_RST = 2'h0;

endpackage : pmb_pkg

// ==== rtl/pmb_top.sv ====
// file: port mirror and broadcast limiter with its register slave
//
// Summary of operation
// - drop a port's broadcast once its count this second passes the threshold
// - each port keeps its own per-second broadcast threshold
// - each port keeps a running total of received broadcasts, readable
// - each port records its highest broadcast count in one second
// - each port reports seconds elapsed since that peak
// - a peak reset clears the peak and its elapsed time together
// - suppression works in bridge or tagged mode, never in secure mode
// - statistics and suppression run independently per port
// - error mirroring is on after reset
// - software adds or removes single source to destination mirror pairs
// - pending mirror edits go live together on commit, lists follow then
// - one source may feed many destinations, destinations may also be sources
// - mirroring only copies, normal forwarding is never blocked by it
// - mirroring works only in transparent bridge mode
`timescale 1ns/10ps
module pmb_top
  import pmb_pkg::*;
#(
  parameter int unsigned N_PORTS    = 10,
  parameter int unsigned CNT_W      = 24,
  parameter int unsigned SEC_CYC    = SEC_CYCLES
) (
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // received frame events from the fabric, one-cycle pulses
  input  wire logic [N_PORTS-1:0]        frm_vld_in,
  input  wire logic [N_PORTS-1:0]        frm_bcast_in,
  input  wire logic [N_PORTS-1:0]        frm_err_in,
  // forwarding decisions, one cycle after the event
  output logic [N_PORTS-1:0]             bcast_drop_out,
  output logic [N_PORTS-1:0]             mir_vld_out,
  output logic [N_PORTS*N_PORTS-1:0]     mir_mask_out,
  // register bus
  input  wire logic [AXI_AW-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [AXI_DW-1:0]         s_axi_wdata,
  input  wire logic [AXI_DW/8-1:0]       s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [AXI_AW-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [AXI_DW-1:0]              s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);

  localparam int unsigned TOT_W = 32;
  localparam int unsigned TIM_W = 32;
  localparam int unsigned PW    = (N_PORTS > 1) ? $clog2(N_PORTS) : 1;

  typedef struct packed {
    logic                              aw_ok;
    logic [AXI_AW-1:0]                 aw_addr;
    logic                              w_ok;
    logic [AXI_DW-1:0]                 w_data;
    logic [AXI_DW/8-1:0]               w_strb;
    logic                              awready;
    logic                              wready;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              arready;
    logic                              rvalid;
    logic [1:0]                        rresp;
    logic [AXI_DW-1:0]                 rdata;
    logic [1:0]                        mode;
    logic [PW-1:0]                     sel;
    logic [N_PORTS-1:0][CNT_W-1:0]     thr;
    logic [N_PORTS-1:0]                peak_clr;
    logic [N_PORTS-1:0][N_PORTS-1:0]   pend_map;
    logic [N_PORTS-1:0][N_PORTS-1:0]   act_map;
    logic [N_PORTS-1:0]                pend_err_drop;
    logic [N_PORTS-1:0]                act_err_drop;
    logic [N_PORTS-1:0]                mir_vld;
    logic [N_PORTS-1:0][N_PORTS-1:0]   mir_mask;
    logic [31:0]                       sec_cnt;
    logic                              tick;
  } pmb_state_t;

  pmb_state_t s_r;
  pmb_state_t s_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;

  logic [N_PORTS-1:0]              port_drop;
  logic [N_PORTS-1:0][TOT_W-1:0]   port_total;
  logic [N_PORTS-1:0][CNT_W-1:0]   port_peak;
  logic [N_PORTS-1:0][TIM_W-1:0]   port_since;
  logic                            lim_en;
  logic                            mir_en;

  // reset is asserted at once and released through two flip-flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign lim_en = (s_r.mode == PMB_MODE_BRIDGE) || (s_r.mode == PMB_MODE_TAGGED);
  assign mir_en = (s_r.mode == PMB_MODE_BRIDGE);

  genvar gi;
  generate
    for (gi = 0; gi < N_PORTS; gi++) begin : g_port
      pmb_bcast_port #(
        .CNT_W (CNT_W),
        .TOT_W (TOT_W),
        .TIM_W (TIM_W)
      ) u_port (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n),
        .tick_in     (s_r.tick),
        .frm_in      (frm_vld_in[gi] && frm_bcast_in[gi]),
        .lim_en_in   (lim_en),
        .thr_in      (s_r.thr[gi]),
        .peak_clr_in (s_r.peak_clr[gi]),
        .drop_out    (port_drop[gi]),
        .total_out   (port_total[gi]),
        .peak_out    (port_peak[gi]),
        .since_out   (port_since[gi])
      );
    end
  endgenerate

  function automatic logic [AXI_DW-1:0] wmerge(input logic [AXI_DW-1:0] old,
                                               input logic [AXI_DW-1:0] data,
                                               input logic [AXI_DW/8-1:0] strb);
    logic [AXI_DW-1:0] res;
    res = old;
    for (int b = 0; b < AXI_DW/8; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : wmerge

  logic [AXI_DW-1:0]     wd;
  logic [PW-1:0]         m_src;
  logic [PW-1:0]         m_dst;
  logic                  m_ok;
  logic                  sel_ok;

  always_comb begin
    s_nxt = s_r;
    wd     = '0;
    m_src  = s_r.w_data[MCMD_SRC_LSB +: PW];
    m_dst  = s_r.w_data[MCMD_DST_LSB +: PW];
    m_ok   = (s_r.w_data[MCMD_SRC_LSB +: MCMD_FLD_W] < N_PORTS) &&
             (s_r.w_data[MCMD_DST_LSB +: MCMD_FLD_W] < N_PORTS);
    sel_ok = (32'(s_r.sel) < N_PORTS);
    s_nxt.peak_clr = '0;

    // one-second timebase
    s_nxt.tick = 1'b0;
    if (s_r.sec_cnt >= SEC_CYC - 1) begin
      s_nxt.sec_cnt = '0;
      s_nxt.tick    = 1'b1;
    end else begin
      s_nxt.sec_cnt = s_r.sec_cnt + 32'h0000_0001;
    end

    // mirror copies; the normal forwarding decision is never touched here
    for (int i = 0; i < N_PORTS; i++) begin
      s_nxt.mir_vld[i]  = mir_en && frm_vld_in[i] && (|s_r.act_map[i]) &&
                          (!frm_err_in[i] || !s_r.act_err_drop[i]);
      s_nxt.mir_mask[i] = s_nxt.mir_vld[i] ? s_r.act_map[i] : '0;
    end

    // write channel
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_ok   = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_ok   = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      unique case (s_r.aw_addr)
        REG_CTRL: begin
          wd = wmerge({30'h0000_0000, s_r.mode}, s_r.w_data, s_r.w_strb);
          s_nxt.mode = wd[CTRL_MODE_LSB +: 2];
          if (wd[CTRL_COMMIT]) begin
            s_nxt.act_map      = s_r.pend_map;
            s_nxt.act_err_drop = s_r.pend_err_drop;
          end
        end
        REG_MIR_CMD: begin
          if (m_ok) begin
            s_nxt.pend_map[m_src][m_dst] = s_r.w_data[MCMD_ADD];
            s_nxt.pend_err_drop[m_src]   = !s_r.w_data[MCMD_ERR_ON];
          end else begin
            s_nxt.bresp = RESP_SLVERR;
          end
        end
        REG_PORT_SEL: begin
          wd = wmerge(AXI_DW'(s_r.sel), s_r.w_data, s_r.w_strb);
          s_nxt.sel = wd[PW-1:0];
        end
        REG_THRESH: begin
          // multiples of ten are expected; any value is stored as written
          if (sel_ok) begin
            wd = wmerge(AXI_DW'(s_r.thr[s_r.sel]), s_r.w_data, s_r.w_strb);
            s_nxt.thr[s_r.sel] = wd[CNT_W-1:0];
          end else begin
            s_nxt.bresp = RESP_SLVERR;
          end
        end
        REG_PEAK_RST: begin
          if (sel_ok) begin
            s_nxt.peak_clr[s_r.sel] = s_r.w_data[PEAK_RST_BIT];
          end else begin
            s_nxt.bresp = RESP_SLVERR;
          end
        end
        REG_TOTAL_RX, REG_PEAK, REG_SINCE, REG_SRC_LIST, REG_DST_LIST, REG_ERR_LIST: begin
          s_nxt.bresp = RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_ok && !s_nxt.bvalid;

    // read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      s_nxt.rdata  = '0;
      unique case (s_axi_araddr)
        REG_CTRL:     s_nxt.rdata = AXI_DW'(s_r.mode);
        REG_PORT_SEL: s_nxt.rdata = AXI_DW'(s_r.sel);
        REG_THRESH:   s_nxt.rdata = sel_ok ? AXI_DW'(s_r.thr[s_r.sel]) : '0;
        REG_TOTAL_RX: s_nxt.rdata = sel_ok ? port_total[s_r.sel] : '0;
        REG_PEAK:     s_nxt.rdata = sel_ok ? AXI_DW'(port_peak[s_r.sel]) : '0;
        REG_SINCE:    s_nxt.rdata = sel_ok ? port_since[s_r.sel] : '0;
        REG_MIR_CMD, REG_PEAK_RST: s_nxt.rdata = '0;
        REG_SRC_LIST: begin
          for (int i = 0; i < N_PORTS; i++) begin
            s_nxt.rdata[i] = |s_r.act_map[i];
          end
        end
        REG_DST_LIST: begin
          for (int i = 0; i < N_PORTS; i++) begin
            for (int j = 0; j < N_PORTS; j++) begin
              s_nxt.rdata[j] = s_nxt.rdata[j] | s_r.act_map[i][j];
            end
          end
        end
        REG_ERR_LIST: begin
          // bit by bit so no inverted padding reaches the unused upper bits
          for (int i = 0; i < N_PORTS; i++) begin
            s_nxt.rdata[i] = !s_r.act_err_drop[i];
          end
        end
        default: begin
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;
  end

  // error mirroring stored as a drop flag so the all-zero reset leaves it on
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bcast_drop_out = port_drop;
  assign mir_vld_out    = s_r.mir_vld;
  assign mir_mask_out   = s_r.mir_mask;
  assign s_axi_awready  = s_r.awready;
  assign s_axi_wready   = s_r.wready;
  assign s_axi_bvalid   = s_r.bvalid;
  assign s_axi_bresp    = s_r.bresp;
  assign s_axi_arready  = s_r.arready;
  assign s_axi_rvalid   = s_r.rvalid;
  assign s_axi_rresp    = s_r.rresp;
  assign s_axi_rdata    = s_r.rdata;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence commit_wr_s;
    s_r.aw_ok && s_r.w_ok && !s_r.bvalid && (s_r.aw_addr == REG_CTRL) &&
      s_r.w_strb[0] && s_r.w_data[CTRL_COMMIT];
  endsequence

  sequence edit_wr_s;
    s_r.aw_ok && s_r.w_ok && !s_r.bvalid && (s_r.aw_addr == REG_MIR_CMD);
  endsequence

  commit_copy_a: assert property (commit_wr_s |=> (s_r.act_map == $past(s_r.pend_map)))
    else $error("commit did not load pending mirror map");
  edit_pending_a: assert property (edit_wr_s |=> (s_r.act_map == $past(s_r.act_map)))
    else $error("mirror edit went live before commit");
  mirror_mode_a: assert property ((s_r.mode != PMB_MODE_BRIDGE) |=> (mir_vld_out == '0))
    else $error("mirror copy outside bridge mode");
  // checked on every port, since any port may be a mirror source
  genvar ai;
  generate
    for (ai = 0; ai < N_PORTS; ai++) begin : g_mir_chk
      mirror_err_a: assert property (@(posedge clk_in) disable iff (!rst_n)
                                     (mir_en && frm_vld_in[ai] && frm_err_in[ai] && s_r.act_err_drop[ai])
                                     |=> !mir_vld_out[ai])
        else $error("errored frame mirrored with error mirroring off");
      mirror_copy_a: assert property (@(posedge clk_in) disable iff (!rst_n)
                                      (mir_en && frm_vld_in[ai] && !frm_err_in[ai] && (|s_r.act_map[ai]))
                                      |=> mir_vld_out[ai]
                                          && (mir_mask_out[ai*N_PORTS +: N_PORTS] == $past(s_r.act_map[ai])))
        else $error("valid frame not mirrored to all destinations");
    end
  endgenerate
  secure_nodrop_a: assert property ((s_r.mode == PMB_SECURE_VLAN_MODE) ##1 (s_r.mode == PMB_SECURE_VLAN_MODE)
                                    |=> (bcast_drop_out == '0))
    else $error("broadcast dropped in secure mode");
  write_resp_a: assert property ((s_r.aw_ok && s_r.w_ok && !s_r.bvalid) |=> s_axi_bvalid)
    else $error("write response missing");

endmodule : pmb_top

// ==== verification/pmb_fabric_model.sv ====
// file: fabric side model, turns frame requests into one-cycle receive pulses
`timescale 1ns/10ps
module pmb_fabric_model
  import pmb_pkg::*;
#(
  parameter int unsigned N = 10
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [N-1:0] req_vld_in,
  input  wire logic [N-1:0] req_bcast_in,
  input  wire logic [N-1:0] req_err_in,
  output logic      [N-1:0] frm_vld_out,
  output logic      [N-1:0] frm_bcast_out,
  output logic      [N-1:0] frm_err_out
);
  // qualifiers flip between frames so the design cannot lean on stale values
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frm_vld_out   <= '0;
      frm_bcast_out <= '0;
      frm_err_out   <= '0;
    end else begin
      frm_vld_out   <= req_vld_in;
      frm_bcast_out <= (req_vld_in & req_bcast_in) | (~req_vld_in & ~frm_bcast_out);
      frm_err_out   <= (req_vld_in & req_err_in) | (~req_vld_in & ~frm_err_out);
    end
  end
endmodule : pmb_fabric_model

// ==== verification/test_pmb_top.sv ====
// file: self-checking bench of the port mirror and broadcast limiter
`timescale 1ns/10ps
module test_pmb_top
  import pmb_pkg::*;
  ;
  localparam int N = 10;
  localparam int SEC = 100;
  logic           clk_in = 1'b0, rst_n_in = 1'b0;
  logic [N-1:0]   rq_v = '0, rq_b = '0, rq_e = '0, fv, fb, fe, drop, mv;
  logic [N*N-1:0] mask;
  logic [7:0]     awaddr = '0, araddr = '0;
  logic [31:0]    wdata = '0, rdata;
  logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic           awready, wready, bvalid, arready, rvalid, fv_d = 1'b0;
  logic [1:0]     bresp, rresp;
  logic [127:0]   wq[$], rq[$], fq[$];
  logic [15:0]    seed = 16'h6279;
  int             fails = 0, comparisons = 0, cyc = 0, p;

  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= rst_n_in ? cyc + 1 : 0;

  pmb_fabric_model #(.N(N)) fab (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_vld_in(rq_v), .req_bcast_in(rq_b),
    .req_err_in(rq_e), .frm_vld_out(fv), .frm_bcast_out(fb), .frm_err_out(fe));
  pmb_top #(.N_PORTS(N), .SEC_CYC(SEC)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .frm_vld_in(fv),
    .frm_bcast_in(fb), .frm_err_in(fe), .bcast_drop_out(drop), .mir_vld_out(mv), .mir_mask_out(mask),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  task automatic stop_test();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [127:0] e, input logic [127:0] a);
    comparisons++;
    if (a !== e) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk

  task automatic tmo();
    fails++;
    stop_test();
  endtask : tmo

  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction : xs

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n = 0;
    wq.push_back(128'(r));
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (!bvalid && n >= 50) tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n = 0;
    rq.push_back({94'h0, r, d});
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (!rvalid && n >= 50) tmo();
  endtask : rd

  // one frame cycle; the expected decisions are noted before the frame leaves
  task automatic fr(input logic [N-1:0] v, b, e, drp, m, input int s, input logic [N-1:0] dm);
    @(posedge clk_in);
    rq_v <= v;
    rq_b <= b;
    rq_e <= e;
    fq.push_back({8'h00, drp, m, 100'(dm) << (s * N)});
  endtask : fr

  task automatic idle();
    @(posedge clk_in);
    rq_v <= '0;
  endtask : idle

  // port 2 drops beyond lim frames; other ports in v have no threshold
  task automatic burst(input int k, input int lim, input logic [N-1:0] v);
    for (int i = 1; i <= k; i++) begin
      fr(v, v, '0, (i > lim) ? 10'h004 : 10'h000, '0, 0, '0);
    end
    idle();
  endtask : burst

  // window phase is only known to a few cycles, so traffic sits mid-window
  task automatic at(input int k);
    while (cyc % SEC != k) @(posedge clk_in);
  endtask : at

  always @(posedge clk_in) begin
    fv_d <= |fv;
    if (bvalid && bready) chk(wq.pop_front(), 128'(bresp));
    if (rvalid && rready) chk(rq.pop_front(), {94'h0, rresp, rdata});
    if (fv_d) chk(fq.pop_front(), {8'h00, drop, mv, mask});
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    tmo();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(REG_ERR_LIST, 32'h3FF);
    rd(REG_CTRL, 32'h0);
    rd(8'h2C, 32'h0, RESP_SLVERR);
    wr(8'h30, {16'h0, xs()}, RESP_SLVERR);
    wr(REG_MIR_CMD, 32'h30A01, RESP_SLVERR);
    wr(REG_PORT_SEL, 32'hF);
    rd(REG_PORT_SEL, 32'hF);
    wr(REG_THRESH, 32'h14, RESP_SLVERR);
    rd(REG_THRESH, 32'h0);
    wr(REG_TOTAL_RX, 32'h5);
    wr(REG_MIR_CMD, 32'h30201);
    wr(REG_MIR_CMD, 32'h30301);
    wr(REG_MIR_CMD, 32'h10104);
    rd(REG_SRC_LIST, 32'h0);
    wr(REG_CTRL, 32'h4);
    rd(REG_SRC_LIST, 32'h12);
    rd(REG_DST_LIST, 32'hE);
    rd(REG_ERR_LIST, 32'h3EF);
    fr(10'h002, '0, 10'h002, '0, 10'h002, 1, 10'h00C);
    fr(10'h010, '0, 10'h010, '0, '0, 0, '0);
    fr(10'h010, 10'h010, '0, '0, 10'h010, 4, 10'h002);
    idle();
    wr(REG_MIR_CMD, 32'h20301);
    wr(REG_CTRL, 32'h4);
    fr(10'h002, '0, '0, '0, 10'h002, 1, 10'h004);
    idle();
    wr(REG_CTRL, 32'h1);
    fr(10'h002, '0, '0, '0, '0, 0, '0);
    idle();
    wr(REG_CTRL, 32'h0);
    wr(REG_PORT_SEL, 32'h2);
    wr(REG_THRESH, 32'hA);
    p = 5 + int'(xs() % 16'h5);
    at(40);
    burst(12, 10, 10'h004 | (10'h001 << p));
    at(40);
    rd(REG_PEAK, 32'hC);
    rd(REG_TOTAL_RX, 32'hC);
    rd(REG_SINCE, 32'h0);
    at(40);
    rd(REG_SINCE, 32'h1);
    wr(REG_PEAK_RST, 32'h1);
    repeat (3) @(posedge clk_in);
    rd(REG_PEAK, 32'h0);
    rd(REG_SINCE, 32'h0);
    wr(REG_CTRL, 32'h1);
    at(40);
    burst(11, 10, 10'h004);
    wr(REG_CTRL, 32'h2);
    at(40);
    burst(11, 99, 10'h004);
    repeat (4) @(posedge clk_in);
    stop_test();
  end
endmodule : test_pmb_top
